//--- src/mcr_pkg.sv
// package: constants and types for the clock run control link
//
// Overview of operation
// - minipci mode needs pin high and enhanced mode
// - minipci: pin a both functions, pin b clock request; code holds interrupt_pin_b_n high there instead
// - pci mode: pin a f0 plus f1 if enhanced
// - d3cold wake advertised only in minipci mode
// - leave driver off while host holds line low
// - host deasserts by driving high then releasing
// - drive low two cycles after host deassertion; code drives low three cycles after the host releases the line
// - veto pulse lasts exactly two cycles
// - host takes over asserting during veto pulse
// - disable bit 30, pm enable bit 29, reset zero
// - 00 veto, 01 pm decides, 1x no veto
// - disabled circuitry never asserts the line
// - writing zero to disable restores veto
// - software disables veto only before d2/d3
// - veto kept while any function in d0
// - veto dropped only when both functions low power
// - wake event re-enables veto until both d0
// - rearm only after both back in d0
// - wake from cts/ring for f0, pin two f1
// - host must implement clock run protocol
package mcr_pkg;
    // device mode straps, three bits
    localparam logic [2:0] MCR_MODE_FIRST_ENH = 3'h3;
    localparam logic [2:0] MCR_MODE_LAST_ENH = 3'h5;
    // control word and its bit positions
    localparam int MCR_CFG_DIS_BIT = 30;
    localparam int MCR_CFG_PM_BIT = 29;
    localparam logic [31:0] MCR_CFG_RESET = 32'h0000_0000;
    // power state encoding of the control/status field
    localparam logic [1:0] MCR_PS_D0 = 2'h0;
    localparam logic [1:0] MCR_PS_D2 = 2'h2;
    // veto timing in bus clocks
    localparam logic [1:0] MCR_VETO_DELAY = 2'h2;
    localparam logic [1:0] MCR_VETO_LEN = 2'h2;
    // host side stop request: cycles it drives high before release
    localparam logic [1:0] MCR_HOST_HIGH_LEN = 2'h1;
    // host side: cycles to wait with line released for veto
    localparam logic [2:0] MCR_HOST_WAIT = 3'h5;
    // software port addresses
    localparam logic [3:0] MCR_ADDR_CFG = 4'h0;
    localparam logic [3:0] MCR_ADDR_PWR = 4'h1;
    localparam logic [3:0] MCR_ADDR_STAT = 4'h2;
    localparam logic [3:0] MCR_ADDR_HCTL = 4'h0;
    localparam logic [3:0] MCR_ADDR_HSTAT = 4'h1;

    typedef enum logic [1:0]
    {
        MCR_VS_IDLE = 2'b00,
        MCR_VS_WAIT = 2'b01,
        MCR_VS_DRIVE = 2'b10
    } mcr_veto_state_t;

    typedef enum logic [2:0]
    {
        MCR_HS_RUN = 3'b000,
        MCR_HS_HIGH = 3'b001,
        MCR_HS_LISTEN = 3'b010,
        MCR_HS_STOPPED = 3'b011,
        MCR_HS_TAKE = 3'b100
    } mcr_host_state_t;
endpackage

//--- src/mcr_link_if.sv
// interface: shared clock run request line between host and card
`timescale 1ns/10ps
interface mcr_link_if;
    logic host_clkrun_out;
    logic host_clkrun_oe;
    logic dev_clkrun_out;
    logic dev_clkrun_oe;
    logic clk_running;
    logic clkrun_line;

    // resolved wire: low wins, pulled up when nobody drives
    assign clkrun_line = !((host_clkrun_oe && !host_clkrun_out)
        || (dev_clkrun_oe && !dev_clkrun_out));

    modport host
    (
        output host_clkrun_out,
        output host_clkrun_oe,
        output clk_running,
        input clkrun_line
    );

    modport dev
    (
        output dev_clkrun_out,
        output dev_clkrun_oe,
        input clk_running,
        input clkrun_line
    );
endinterface

//--- src/mcr_sync2.sv
// module: two flip-flop synchroniser for one level
`timescale 1ns/10ps
module mcr_sync2
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    // first stage feeds only the second
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            meta_q <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- src/mcr_device.sv
// module: card end of the clock run link with mode and pin mapping
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/10ps
module mcr_device
    import mcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    mcr_link_if.dev link,
    input wire logic minipci_sel_pin,
    input wire logic [2:0] device_mode,
    input wire logic f0_int_req,
    input wire logic f1_int_req,
    input wire logic f0_wake_cts_n,
    input wire logic f0_wake_ri_n,
    input wire logic wake_source_pin_two,
    input wire logic eeprom_load,
    input wire logic [31:0] eeprom_data,
    input wire logic [3:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic interrupt_pin_a_n,
    output logic interrupt_pin_b_n,
    output logic pme_d3cold_cap,
    output logic pme_n
);
    logic line_s;
    logic pin_s;
    logic cts_s;
    logic ri_s;
    logic pin2_s;
    logic line_prev_q;
    logic [31:0] multipurpose_io_config_reg;
    logic [1:0] f0_ps_q;
    logic [1:0] f1_ps_q;
    logic wake_hold_q;
    logic [1:0] cnt_q;
    logic minipci;
    logic enhanced;
    logic both_low;
    logic both_d0;
    logic wake_evt;
    logic veto_en;
    mcr_veto_state_t vs_q;

    // the line, the select pin and the wake inputs pass two flops first
    mcr_sync2 u_sync_line (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .async_in(link.clkrun_line), .sync_out(line_s));
    mcr_sync2 u_sync_pin (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .async_in(minipci_sel_pin), .sync_out(pin_s));
    mcr_sync2 u_sync_cts (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .async_in(f0_wake_cts_n), .sync_out(cts_s));
    mcr_sync2 u_sync_ri (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .async_in(f0_wake_ri_n), .sync_out(ri_s));
    mcr_sync2 u_sync_p2 (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .async_in(wake_source_pin_two), .sync_out(pin2_s));

    // mode decode
    assign enhanced = (device_mode >= MCR_MODE_FIRST_ENH)
        && (device_mode <= MCR_MODE_LAST_ENH);
    assign minipci = pin_s && enhanced;
    // low power means d2 or d3 in the state field
    assign both_low = (f0_ps_q >= MCR_PS_D2) && (f1_ps_q >= MCR_PS_D2);
    assign both_d0 = (f0_ps_q == MCR_PS_D0) && (f1_ps_q == MCR_PS_D0);
    // wake sources while powered down: cts and ring active low, pin two active high
    assign wake_evt = ((!cts_s || !ri_s) && (f0_ps_q >= MCR_PS_D2))
        || (pin2_s && (f1_ps_q >= MCR_PS_D2));

    // control decode: 00 veto, 01 pm decides, 1x off
    always_comb
    begin
        if (multipurpose_io_config_reg[MCR_CFG_DIS_BIT])
            veto_en = 1'b0;
        else if (multipurpose_io_config_reg[MCR_CFG_PM_BIT])
            veto_en = !both_low || wake_hold_q;
        else
            veto_en = 1'b1;
    end

    // control word, writable by software or eeprom load
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            multipurpose_io_config_reg <= MCR_CFG_RESET;
        else if (eeprom_load)
            multipurpose_io_config_reg <= eeprom_data;
        else if (sw_wr && sw_addr == MCR_ADDR_CFG)
            multipurpose_io_config_reg <= sw_wdata;
    end

    // per function power state fields
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            f0_ps_q <= MCR_PS_D0;
            f1_ps_q <= MCR_PS_D0;
        end
        else if (sw_wr && sw_addr == MCR_ADDR_PWR)
        begin
            f0_ps_q <= sw_wdata[1:0];
            f1_ps_q <= sw_wdata[9:8];
        end
    end

    // wake holds veto on until both functions back in d0
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            wake_hold_q <= 1'b0;
        else if (wake_evt)
            wake_hold_q <= 1'b1;
        else if (both_d0)
            wake_hold_q <= 1'b0;
    end

    // veto sequencer on the shared line
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            vs_q <= MCR_VS_IDLE;
            cnt_q <= 2'h0;
            line_prev_q <= 1'b1; // matches sync reset level, no false edge
            link.dev_clkrun_oe <= 1'b0;
            link.dev_clkrun_out <= 1'b1;
        end
        else
        begin
            line_prev_q <= line_s;
            case (vs_q)
                MCR_VS_IDLE:
                begin
                    link.dev_clkrun_oe <= 1'b0;
                    // rising edge seen on line: host deasserted
                    if (minipci && veto_en && line_s && !line_prev_q)
                    begin
                        vs_q <= MCR_VS_WAIT;
                        cnt_q <= 2'h0;
                    end
                end
                MCR_VS_WAIT:
                begin
                    // sync delay covers the first edges
                    vs_q <= MCR_VS_DRIVE;
                    link.dev_clkrun_oe <= 1'b1;
                    link.dev_clkrun_out <= 1'b0;
                    cnt_q <= 2'h1;
                end
                MCR_VS_DRIVE:
                begin
                    if (cnt_q == MCR_VETO_LEN)
                    begin
                        link.dev_clkrun_oe <= 1'b0;
                        link.dev_clkrun_out <= 1'b1;
                        vs_q <= MCR_VS_IDLE;
                    end
                    else
                        cnt_q <= cnt_q + 2'h1;
                end
                default:
                    vs_q <= MCR_VS_IDLE;
            endcase
        end
    end

    // interrupt pin mapping and capability flag
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            interrupt_pin_a_n <= 1'b1;
            interrupt_pin_b_n <= 1'b1;
            pme_d3cold_cap <= 1'b0;
            pme_n <= 1'b1;
        end
        else
        begin
            if (minipci || enhanced)
            begin
                interrupt_pin_a_n <= !(f0_int_req || f1_int_req);
                interrupt_pin_b_n <= 1'b1;
            end
            else
            begin
                interrupt_pin_a_n <= !f0_int_req;
                interrupt_pin_b_n <= !f1_int_req;
            end
            pme_d3cold_cap <= minipci;
            pme_n <= !wake_hold_q;
        end
    end

    // read port, data one cycle after strobe
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            sw_rdata <= 32'h0000_0000;
        else if (sw_rd)
        begin
            case (sw_addr)
                MCR_ADDR_CFG: sw_rdata <= multipurpose_io_config_reg;
                MCR_ADDR_PWR: sw_rdata <= {22'h0, f1_ps_q, 6'h0, f0_ps_q};
                MCR_ADDR_STAT: sw_rdata <= {27'h0, wake_hold_q, veto_en,
                    minipci, vs_q};
                default: sw_rdata <= 32'h0000_0000;
            endcase
        end
        else
            sw_rdata <= 32'h0000_0000;
    end
endmodule

//--- src/mcr_host.sv
// module: central resource end that asks to stop the bus clock
`timescale 1ns/10ps
module mcr_host
    import mcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    mcr_link_if.host link,
    input wire logic [3:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata
);
    logic [2:0] cnt_q;
    logic vetoed_q;
    logic stop_req;
    mcr_host_state_t hs_q;

    // line is driven by logic on this same clock, so it is read without a
    // synchroniser: two flops of delay would miss the two-cycle veto pulse
    assign stop_req = sw_wr && sw_addr == MCR_ADDR_HCTL && sw_wdata[0];

    // stop request sequence on the shared line
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            hs_q <= MCR_HS_RUN;
            cnt_q <= 3'h0;
            vetoed_q <= 1'b0;
            link.host_clkrun_oe <= 1'b1;
            link.host_clkrun_out <= 1'b0;
            link.clk_running <= 1'b1;
        end
        else
        begin
            case (hs_q)
                MCR_HS_RUN:
                begin
                    link.host_clkrun_oe <= 1'b1;
                    link.host_clkrun_out <= 1'b0;
                    link.clk_running <= 1'b1;
                    if (stop_req)
                    begin
                        link.host_clkrun_out <= 1'b1;
                        cnt_q <= 3'h0;
                        hs_q <= MCR_HS_HIGH;
                    end
                end
                MCR_HS_HIGH:
                begin
                    if (cnt_q[1:0] + 2'h1 >= MCR_HOST_HIGH_LEN)
                    begin
                        link.host_clkrun_oe <= 1'b0;
                        cnt_q <= 3'h0;
                        hs_q <= MCR_HS_LISTEN;
                    end
                    else
                        cnt_q <= cnt_q + 3'h1;
                end
                MCR_HS_LISTEN:
                begin
                    if (!link.clkrun_line)
                    begin
                        link.host_clkrun_oe <= 1'b1;
                        link.host_clkrun_out <= 1'b0;
                        vetoed_q <= 1'b1;
                        hs_q <= MCR_HS_TAKE;
                    end
                    else if (cnt_q == MCR_HOST_WAIT)
                    begin
                        link.clk_running <= 1'b0;
                        vetoed_q <= 1'b0;
                        hs_q <= MCR_HS_STOPPED;
                    end
                    else
                        cnt_q <= cnt_q + 3'h1;
                end
                MCR_HS_TAKE:
                    hs_q <= MCR_HS_RUN;
                MCR_HS_STOPPED:
                begin
                    // any software access restarts the clock
                    if (sw_wr || sw_rd)
                    begin
                        link.clk_running <= 1'b1;
                        link.host_clkrun_oe <= 1'b1;
                        link.host_clkrun_out <= 1'b0;
                        hs_q <= MCR_HS_RUN;
                    end
                end
                default:
                    hs_q <= MCR_HS_RUN;
            endcase
        end
    end

    // status read port, data one cycle after strobe
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            sw_rdata <= 32'h0000_0000;
        else if (sw_rd && sw_addr == MCR_ADDR_HSTAT)
            sw_rdata <= {27'h0, vetoed_q, link.clk_running, hs_q};
        else
            sw_rdata <= 32'h0000_0000;
    end
endmodule

//--- testbench/mcr_link_properties.sv
// checker: timing properties of the shared clock run line
`timescale 1ns/10ps
module mcr_link_properties
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic host_clkrun_out,
    input wire logic host_clkrun_oe,
    input wire logic dev_clkrun_out,
    input wire logic dev_clkrun_oe,
    input wire logic clk_running,
    input wire logic clkrun_line
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    logic host_low;
    // host actively holding the line low
    assign host_low = host_clkrun_oe && !host_clkrun_out;
    veto_after_release_a: assert property ($rose(dev_clkrun_oe) |->
        $past(clkrun_line, 3) && $past(clkrun_line, 4))
        else $error("veto started without a host release");
    veto_two_cycles_a: assert property ($rose(dev_clkrun_oe) |->
        dev_clkrun_oe[*2] ##1 !dev_clkrun_oe)
        else $error("veto pulse not two cycles");
    veto_drives_low_a: assert property (dev_clkrun_oe |->
        !dev_clkrun_out && !clkrun_line)
        else $error("veto does not pull the line low");
    quiet_host_low_a: assert property (host_low[*4] |-> !$rose(dev_clkrun_oe))
        else $error("device drove while host held line low");
    release_after_high_a: assert property ($fell(host_clkrun_oe) |->
        $past(host_clkrun_out) && $past(host_clkrun_oe))
        else $error("host released without driving high");
    host_takeover_a: assert property ($fell(dev_clkrun_oe) |-> ##[0:2] host_low)
        else $error("host did not take over the line");
    stop_released_a: assert property ($fell(clk_running) |->
        $past(clkrun_line, 1) && $past(clkrun_line, 3) && !dev_clkrun_oe)
        else $error("clock stopped on a held line");
    stop_resolved_a: assert property ($rose(clkrun_line) |->
        ##[1:10] (dev_clkrun_oe || !clk_running))
        else $error("stop request left unresolved");
    signalled_stop_a: assert property ($fell(clk_running) |->
        $past(host_clkrun_out, 7) && !$past(host_clkrun_oe, 6) && !$past(host_clkrun_oe))
        else $error("clock stopped without a host release");
    veto_c: cover property ($rose(dev_clkrun_oe));
    stop_c: cover property ($fell(clk_running));
    takeover_c: cover property ($fell(dev_clkrun_oe) ##1 host_low);
endmodule

//--- testbench/mcr_link_tb.sv
// testbench: host and card ends joined over the clock run link
`timescale 1ns/10ps
module mcr_link_tb
    import mcr_pkg::*;
;
    logic ref_clk, sys_rst, minipci_sel_pin, f0_int_req, f1_int_req;
    logic f0_wake_cts_n, f0_wake_ri_n, wake_source_pin_two, eeprom_load;
    logic [2:0] device_mode;
    logic [31:0] eeprom_data, d_wdata, d_rdata, h_wdata, h_rdata;
    logic [3:0] d_addr, h_addr;
    logic d_wr, d_rd, h_wr, h_rd, int_a_n, int_b_n, cap, pme_n;
    int checked, bad_count, cycles;
    mcr_link_if link();
    mcr_device mcr_device_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
        .minipci_sel_pin(minipci_sel_pin), .device_mode(device_mode),
        .f0_int_req(f0_int_req), .f1_int_req(f1_int_req), .f0_wake_cts_n(f0_wake_cts_n),
        .f0_wake_ri_n(f0_wake_ri_n), .wake_source_pin_two(wake_source_pin_two),
        .eeprom_load(eeprom_load), .eeprom_data(eeprom_data), .sw_addr(d_addr),
        .sw_wdata(d_wdata), .sw_wr(d_wr), .sw_rd(d_rd), .sw_rdata(d_rdata),
        .interrupt_pin_a_n(int_a_n), .interrupt_pin_b_n(int_b_n),
        .pme_d3cold_cap(cap), .pme_n(pme_n));
    mcr_host mcr_host_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
        .sw_addr(h_addr), .sw_wdata(h_wdata), .sw_wr(h_wr), .sw_rd(h_rd),
        .sw_rdata(h_rdata));
    mcr_link_properties mcr_link_properties_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .host_clkrun_out(link.host_clkrun_out), .host_clkrun_oe(link.host_clkrun_oe),
        .dev_clkrun_out(link.dev_clkrun_out), .dev_clkrun_oe(link.dev_clkrun_oe),
        .clk_running(link.clk_running), .clkrun_line(link.clkrun_line));
    // bus clock, 50 ns period
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = !ref_clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            complete_run();
        end
    end
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic dwr(logic [3:0] a, logic [31:0] d);
        @(posedge ref_clk);
        d_addr <= a;
        d_wdata <= d;
        d_wr <= 1'b1;
        @(posedge ref_clk);
        d_wr <= 1'b0;
    endtask
    task automatic drd(string what, logic [3:0] a, logic [31:0] e);
        @(posedge ref_clk);
        d_addr <= a;
        d_rd <= 1'b1;
        @(posedge ref_clk);
        d_rd <= 1'b0;
        #1;
        chk(what, d_rdata, e);
    endtask
    // host strobe: write asks for a stop, read restarts a stopped clock
    task automatic hcmd(logic wr);
        @(posedge ref_clk);
        h_addr <= wr ? MCR_ADDR_HCTL : MCR_ADDR_HSTAT;
        h_wr <= wr;
        h_rd <= !wr;
        @(posedge ref_clk);
        h_wr <= 1'b0;
        h_rd <= 1'b0;
    endtask
    task automatic pins(logic [3:0] e);
        repeat (4) @(posedge ref_clk);
        #1;
        chk("pins", {28'h0, int_a_n, int_b_n, cap, pme_n}, {28'h0, e});
    endtask
    // stop attempt: counts veto cycles and notes a stopped clock
    task automatic try_stop(string what, logic veto);
        int n;
        logic stopped;
        n = 0;
        stopped = 1'b0;
        hcmd(1'b1);
        repeat (20)
        begin
            @(posedge ref_clk);
            #1;
            if (link.dev_clkrun_oe === 1'b1)
                n++;
            if (link.clk_running !== 1'b1)
                stopped = 1'b1;
        end
        chk(what, {stopped, n[30:0]}, veto ? 32'h2 : 32'h8000_0000);
        // status read, also restarts a stopped clock
        hcmd(1'b0);
        #1;
        chk("host status", h_rdata, veto ? 32'h18 : {29'h0, MCR_HS_STOPPED});
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic do_reset(logic pin, logic [2:0] mode);
        @(posedge ref_clk);
        minipci_sel_pin <= pin;
        device_mode <= mode;
        sys_rst <= 1'b1;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    // main sequence
    initial
    begin
        {sys_rst, minipci_sel_pin, f0_int_req, f1_int_req, eeprom_load} = 5'h18;
        {f0_wake_cts_n, f0_wake_ri_n, wake_source_pin_two} = 3'h6;
        {d_wr, d_rd, h_wr, h_rd, d_addr, h_addr} = 12'h0;
        {device_mode, eeprom_data, d_wdata, h_wdata} = {3'h3, 64'h0, 32'h1};
        {checked, bad_count, cycles} = '0;
        do_reset(1'b1, 3'h3);
        drd("cfg", MCR_ADDR_CFG, 32'h0);
        drd("status", MCR_ADDR_STAT, 32'hc);
        f1_int_req <= 1'b1;
        pins(4'h7);
        for (int i = 0; i < 4; i++)
        begin
            dwr(MCR_ADDR_CFG, 32'(i) << 29);
            try_stop("control code", i < 2);
        end
        dwr(MCR_ADDR_CFG, 32'h0);
        try_stop("reenable", 1'b1);
        dwr(MCR_ADDR_PWR, 32'h0303);
        @(posedge ref_clk);
        eeprom_data <= 32'h4000_0000;
        eeprom_load <= 1'b1;
        @(posedge ref_clk);
        eeprom_load <= 1'b0;
        drd("eeprom cfg", MCR_ADDR_CFG, 32'h4000_0000);
        try_stop("disabled", 1'b0);
        $display("control tests done");
        dwr(MCR_ADDR_CFG, 32'h2000_0000);
        dwr(MCR_ADDR_PWR, 32'h0300);
        try_stop("one in d0", 1'b1);
        dwr(MCR_ADDR_PWR, 32'h0302);
        try_stop("both low", 1'b0);
        for (int k = 0; k < 3; k++)
        begin
            f0_wake_cts_n <= (k != 0);
            f0_wake_ri_n <= (k != 1);
            wake_source_pin_two <= (k == 2);
            pins(4'h6);
            {f0_wake_cts_n, f0_wake_ri_n, wake_source_pin_two} <= 3'h6;
            try_stop("wake veto", 1'b1);
            dwr(MCR_ADDR_PWR, 32'h0202);
            try_stop("no rearm", 1'b1);
            dwr(MCR_ADDR_PWR, 32'h0);
            dwr(MCR_ADDR_PWR, 32'h0303);
            try_stop("rearmed", 1'b0);
        end
        $display("power tests done");
        do_reset(1'b0, 3'h5);
        pins(4'h5);
        try_stop("pci mode", 1'b0);
        do_reset(1'b1, 3'h2);
        pins(4'h9);
        try_stop("compat mode", 1'b0);
        $display("mode tests done");
        complete_run();
    end
endmodule
